// ==== hw/fdcif_pkg.sv ====
package fdcif_pkg;
  // register address codes
  localparam logic [1:0] ADDR_STATUS_COMMAND = 2'h0;
  localparam logic [1:0] ADDR_TRACK = 2'h1;
  localparam logic [1:0] ADDR_SECTOR = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;
  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DRQ = 1;
  localparam int ST_LOST = 2;
  localparam int ST_CRC = 3;
  localparam int ST_RNF = 4;
  localparam int ST_SPIN = 5;
  localparam int ST_WPROT = 6;
  localparam int ST_MOTOR = 7;
  // command classes by upper nibble
  localparam logic [3:0] CMD_TYPE1_MAX = 4'h7;
  localparam logic [3:0] CMD_READ_SECTOR = 4'h8;
  localparam logic [3:0] CMD_WRITE_SECTOR = 4'hA;
  localparam logic [3:0] CMD_READ_ADDRESS = 4'hC;
  localparam logic [3:0] CMD_FORCE_INT = 4'hD;
  localparam logic [3:0] CMD_READ_TRACK = 4'hE;
  localparam logic [3:0] CMD_WRITE_TRACK = 4'hF;
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] RESET_TRACK = 8'h00;
  localparam logic [7:0] RESET_SECTOR = 8'h01;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int BYTE_TIME_US = 32;
  localparam int BYTE_CYCLES = BYTE_TIME_US * CLK_MHZ;
  localparam int SECTOR_BYTES = 256;
  localparam int TRACK_BYTES = 6250;
  localparam int SPINUP_REVS = 5;
  localparam int TYPE1_CYCLES = 64;
endpackage

// ==== hw/fdcif_skid.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdcif_skid #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  wire push = in_valid_in && (cnt_q != 2'h2);
  wire pop = out_ready_in && (cnt_q != 2'h0);
  assign in_ready_out = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out = mem_q[rd_q];
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
    if (rst_in) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // fdcif_skid
`default_nettype wire

// ==== hw/fdcif_top.sv ====
// How it works
// - address 00 reads status, writes command register.
// - codes 01,10,11 reach track, sector and data registers.
// - read shifts disk bits into bytes, raising a request per byte.
// - data register read or write clears request bit and output.
// - write requests once sector found; processor writes a byte.
// - each latched byte asserts write gate; repeats to sector end.
// - write-inhibit low aborts write commands, sets bit 6.
// - a non-force command written while idle sets busy and motor on, clears other status bits.
// - interrupt output follows busy; busy only while executing.
// - status bit 7 mirrors motor-on output.
// - bit 5 spin-up on type 1, record type otherwise.
// - bit 4 flags record not found, cleared on update.
// - bit 3 flags crc error, cleared on update.
// - bit 2 lost data, or track zero on type 1.
// - bit 1 copies request, or index on type 1.
// - force interrupt clears busy; idle clears other bits too.
// - write track sets busy, requests each track byte.
// - active-low reset initializes device and status.
`timescale 1ns/1ps
`default_nettype none
module fdcif_top #(
  parameter int BYTE_CYC = fdcif_pkg::BYTE_CYCLES,
  parameter int SECTOR_LEN = fdcif_pkg::SECTOR_BYTES,
  parameter int TRACK_LEN = fdcif_pkg::TRACK_BYTES,
  parameter int TYPE1_CYC = fdcif_pkg::TYPE1_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic io_reset_n_in,
  input wire logic select_n_in,
  input wire logic bus_read_write_line_in,
  input wire logic [1:0] register_address_bits_in,
  input wire logic [7:0] io_data_bus_in,
  output logic [7:0] io_data_bus_out,
  output logic io_data_bus_oe_out,
  output logic byte_transfer_request_out,
  output logic floppy_irq_out,
  input wire logic write_inhibit_n_in,
  input wire logic track_zero_sense_n_in,
  input wire logic index_n_in,
  input wire logic read_data_in,
  input wire logic read_bit_valid_in,
  input wire logic record_found_in,
  input wire logic record_not_found_in,
  input wire logic crc_error_in,
  input wire logic deleted_mark_in,
  output logic motor_on_out,
  output logic write_gate_out,
  output logic write_data_out,
  output logic [7:0] write_byte_out,
  output logic write_byte_valid_out,
  input wire logic write_byte_ready_in
);
  typedef enum logic [2:0] {
    FDCIF_IDLE, FDCIF_TYPE1, FDCIF_SEEK, FDCIF_READ, FDCIF_WRITE, FDCIF_ABORT
  } fdcif_state_type;

  // a level only moves once the last two stages agree
  function automatic logic agree3(input logic [2:0] s);
    agree3 = (s[1] == s[2]);
  endfunction

  // pin inputs: three stages, change counts when stages 2 and 3 agree
  logic [2:0] sel_s_q, rw_s_q, wp_s_q, tz_s_q, ix_s_q, rst_s_q;
  logic sel_n_q, rw_q, wp_n_q, tz_n_q, ix_n_q, rstn_q;
  logic [1:0] adr_q;
  logic [7:0] din_q;
  always_ff @(posedge clk_sys_in) begin
    sel_s_q <= {sel_s_q[1:0], select_n_in};
    rw_s_q <= {rw_s_q[1:0], bus_read_write_line_in};
    wp_s_q <= {wp_s_q[1:0], write_inhibit_n_in};
    tz_s_q <= {tz_s_q[1:0], track_zero_sense_n_in};
    ix_s_q <= {ix_s_q[1:0], index_n_in};
    rst_s_q <= {rst_s_q[1:0], io_reset_n_in};
    adr_q <= register_address_bits_in;
    din_q <= io_data_bus_in;
    // filtered levels start idle so nothing fires out of reset
    if (rst_in) begin
      sel_n_q <= 1'b1;
      rw_q <= 1'b1;
      wp_n_q <= 1'b1;
      tz_n_q <= 1'b1;
      ix_n_q <= 1'b1;
      rstn_q <= 1'b1;
    end else begin
      if (agree3(sel_s_q)) sel_n_q <= sel_s_q[2];
      if (agree3(rw_s_q)) rw_q <= rw_s_q[2];
      if (agree3(wp_s_q)) wp_n_q <= wp_s_q[2];
      if (agree3(tz_s_q)) tz_n_q <= tz_s_q[2];
      if (agree3(ix_s_q)) ix_n_q <= ix_s_q[2];
      if (agree3(rst_s_q)) rstn_q <= rst_s_q[2];
    end
  end

  // access strobes once per select cycle
  logic sel_d1_q;
  always_ff @(posedge clk_sys_in) sel_d1_q <= ~sel_n_q;
  wire access_go = ~sel_n_q & ~sel_d1_q;
  wire wr_go = access_go & ~rw_q;
  wire rd_go = access_go & rw_q;
  // decode on address and direction
  wire wr_cmd = wr_go & (adr_q == fdcif_pkg::ADDR_STATUS_COMMAND);
  wire wr_trk = wr_go & (adr_q == fdcif_pkg::ADDR_TRACK);
  wire wr_sec = wr_go & (adr_q == fdcif_pkg::ADDR_SECTOR);
  wire wr_dat = wr_go & (adr_q == fdcif_pkg::ADDR_DATA);
  wire rd_dat = rd_go & (adr_q == fdcif_pkg::ADDR_DATA);
  wire [3:0] op = din_q[7:4];
  wire is_force = (op == fdcif_pkg::CMD_FORCE_INT);
  wire is_type1 = (op <= fdcif_pkg::CMD_TYPE1_MAX);
  wire is_write = (op == fdcif_pkg::CMD_WRITE_SECTOR) || (op == fdcif_pkg::CMD_WRITE_TRACK)
    || (op == 4'hB);
  wire is_wtrack = (op == fdcif_pkg::CMD_WRITE_TRACK);
  wire soft_rst = rst_in | ~rstn_q;

  fdcif_state_type st_q;
  logic [7:0] status_q, track_q, sector_q, data_q, shift_q;
  logic [2:0] bitcnt_q;
  logic drq_q, lost_q, type1_q, wtrack_q, motor_q, spin_q;
  logic [15:0] bytes_q;
  logic [15:0] timer_q;
  logic [2:0] revs_q;
  logic ix_d_q;
  logic hold_byte_q;
  logic dir_write_q;
  wire byte_due = (timer_q == 16'(BYTE_CYC - 1));
  wire idx_edge = ~ix_n_q & ix_d_q;
  wire sec_end = (bytes_q == 16'(SECTOR_LEN - 1));
  wire trk_end = (bytes_q == 16'(TRACK_LEN - 1));

  // buffer toward the write serializer; a stall holds the byte
  logic skid_in_ready, skid_out_valid;
  logic [7:0] skid_out_data;
  logic push_byte;
  // output stage drains the buffer only when empty or taken
  wire skid_take = ~write_byte_valid_out | write_byte_ready_in;
  fdcif_skid #(.WIDTH(8)) u_skid (
    .clk_sys_in(clk_sys_in),
    .rst_in(soft_rst),
    .in_valid_in(push_byte),
    .in_ready_out(skid_in_ready),
    .in_data_in(data_q),
    .out_valid_out(skid_out_valid),
    .out_ready_in(skid_take),
    .out_data_out(skid_out_data)
  );

  always_ff @(posedge clk_sys_in) begin
    ix_d_q <= ix_n_q;
    if (soft_rst) begin
      st_q <= FDCIF_IDLE;
      status_q <= fdcif_pkg::RESET_STATUS;
      track_q <= fdcif_pkg::RESET_TRACK;
      sector_q <= fdcif_pkg::RESET_SECTOR;
      data_q <= 8'h00;
      shift_q <= 8'h00;
      bitcnt_q <= 3'h0;
      drq_q <= 1'b0;
      lost_q <= 1'b0;
      type1_q <= 1'b0;
      wtrack_q <= 1'b0;
      motor_q <= 1'b0;
      spin_q <= 1'b0;
      bytes_q <= 16'h0000;
      timer_q <= 16'h0000;
      revs_q <= 3'h0;
      hold_byte_q <= 1'b0;
      push_byte <= 1'b0;
    end else begin
      push_byte <= 1'b0;
      // track and sector hold written values
      if (wr_trk) track_q <= din_q;
      if (wr_sec) sector_q <= din_q;
      if (rd_dat | wr_dat) drq_q <= 1'b0;
      if (wr_dat) data_q <= din_q;
      if (wr_dat) hold_byte_q <= 1'b1;
      timer_q <= byte_due ? 16'h0000 : timer_q + 16'h0001;
      if (wr_cmd && is_force) begin
        st_q <= FDCIF_IDLE;
        drq_q <= 1'b0;
        if (st_q == FDCIF_IDLE) status_q[6:2] <= 5'h00;
        if (st_q == FDCIF_IDLE) lost_q <= 1'b0;
      end else if (wr_cmd && st_q == FDCIF_IDLE) begin
        status_q[6:2] <= 5'h00;
        lost_q <= 1'b0;
        drq_q <= 1'b0;
        motor_q <= 1'b1;
        spin_q <= 1'b0;
        revs_q <= 3'h0;
        type1_q <= is_type1;
        wtrack_q <= is_wtrack;
        bytes_q <= 16'h0000;
        timer_q <= 16'h0000;
        bitcnt_q <= 3'h0;
        hold_byte_q <= 1'b0;
        if (is_write && !wp_n_q) begin
          status_q[fdcif_pkg::ST_WPROT] <= 1'b1;
          st_q <= FDCIF_ABORT;
        end else if (is_type1) begin
          st_q <= FDCIF_TYPE1;
        end else if (is_wtrack) begin
          // format requests first byte at once
          st_q <= FDCIF_WRITE;
          drq_q <= 1'b1;
        end else begin
          st_q <= FDCIF_SEEK;
        end
      end else begin
        if (idx_edge && st_q != FDCIF_IDLE && revs_q != 3'(fdcif_pkg::SPINUP_REVS)) begin
          revs_q <= revs_q + 3'h1;
        end
        if (revs_q == 3'(fdcif_pkg::SPINUP_REVS)) spin_q <= 1'b1;
        case (st_q)
          FDCIF_IDLE: begin
          end
          // one busy cycle gives the aborted write its interrupt
          FDCIF_ABORT: st_q <= FDCIF_IDLE;
          FDCIF_TYPE1: begin
            // own count; the byte timer wraps far later
            bytes_q <= bytes_q + 16'h0001;
            if (bytes_q == 16'(TYPE1_CYC - 1)) st_q <= FDCIF_IDLE;
          end
          FDCIF_SEEK: begin
            if (record_not_found_in) begin
              status_q[fdcif_pkg::ST_RNF] <= 1'b1;
              status_q[fdcif_pkg::ST_CRC] <= crc_error_in;
              st_q <= FDCIF_IDLE;
            end else if (record_found_in) begin
              status_q[fdcif_pkg::ST_SPIN] <= deleted_mark_in;
              timer_q <= 16'h0000;
              if (wtrack_q == 1'b0 && dir_write_q) begin
                st_q <= FDCIF_WRITE;
                drq_q <= 1'b1;
              end else begin
                st_q <= FDCIF_READ;
              end
            end
          end
          FDCIF_READ: begin
            // busy holds until the last byte is taken
            if (bytes_q == 16'(SECTOR_LEN)) begin
              if (!drq_q) st_q <= FDCIF_IDLE;
            // shift serial bits into a byte
            end else if (read_bit_valid_in) begin
              shift_q <= {shift_q[6:0], read_data_in};
              bitcnt_q <= bitcnt_q + 3'h1;
              if (bitcnt_q == 3'h7) begin
                data_q <= {shift_q[6:0], read_data_in};
                if (drq_q && !(rd_dat)) lost_q <= 1'b1;
                drq_q <= 1'b1;
                bytes_q <= bytes_q + 16'h0001;
                if (sec_end) begin
                  status_q[fdcif_pkg::ST_CRC] <= crc_error_in;
                end
              end
            end
          end
          FDCIF_WRITE: begin
            // latched byte goes out each byte time
            if (byte_due) begin
              if (hold_byte_q && skid_in_ready) begin
                push_byte <= 1'b1;
                hold_byte_q <= 1'b0;
              end else if (drq_q) begin
                lost_q <= 1'b1;
              end
              bytes_q <= bytes_q + 16'h0001;
              if ((wtrack_q && trk_end) || (!wtrack_q && sec_end)) begin
                st_q <= FDCIF_IDLE;
                drq_q <= 1'b0;
              end else begin
                drq_q <= 1'b1;
              end
            end
          end
          default: st_q <= FDCIF_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (soft_rst) begin
      dir_write_q <= 1'b0;
    end else if (wr_cmd && !is_force && st_q == FDCIF_IDLE) begin
      dir_write_q <= is_write;
    end
  end

  // busy only while a command runs
  wire busy = (st_q != FDCIF_IDLE);
  wire [7:0] status_view = {motor_q, status_q[6],
    type1_q ? spin_q : status_q[5], status_q[4:3],
    type1_q ? ~tz_n_q : lost_q, type1_q ? ~ix_n_q : drq_q, busy};
  wire [7:0] rd_mux = (adr_q == fdcif_pkg::ADDR_STATUS_COMMAND) ? status_view :
    (adr_q == fdcif_pkg::ADDR_TRACK) ? track_q :
    (adr_q == fdcif_pkg::ADDR_SECTOR) ? sector_q : data_q;
  logic write_gate_q;
  always_ff @(posedge clk_sys_in) begin
    if (soft_rst) begin
      io_data_bus_out <= 8'h00;
      io_data_bus_oe_out <= 1'b0;
      byte_transfer_request_out <= 1'b0;
      floppy_irq_out <= 1'b0;
      motor_on_out <= 1'b0;
      write_gate_out <= 1'b0;
      write_data_out <= 1'b0;
      write_byte_out <= 8'h00;
      write_byte_valid_out <= 1'b0;
      write_gate_q <= 1'b0;
    end else begin
      io_data_bus_out <= rd_mux;
      io_data_bus_oe_out <= ~sel_n_q & rw_q;
      byte_transfer_request_out <= drq_q & ~(rd_dat | wr_dat);
      floppy_irq_out <= busy;
      motor_on_out <= motor_q;
      // gate on after first latched byte, held until the last byte drains
      if (push_byte) begin
        write_gate_q <= 1'b1;
      end else if (st_q != FDCIF_WRITE && !skid_out_valid && !write_byte_valid_out) begin
        write_gate_q <= 1'b0;
      end
      write_gate_out <= write_gate_q | push_byte;
      // registered stage keeps valid and ready in step with the sink
      if (skid_out_valid && skid_take) begin
        write_data_out <= skid_out_data[7];
        write_byte_out <= skid_out_data;
        write_byte_valid_out <= 1'b1;
      end else if (write_byte_ready_in) begin
        write_byte_valid_out <= 1'b0;
      end
    end
  end
endmodule // fdcif_top
`default_nettype wire

// ==== verification/fdcif_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdcif_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic select_n_in,
  input wire logic bus_read_write_line_in,
  input wire logic [1:0] register_address_bits_in,
  input wire logic write_inhibit_n_in,
  input wire logic io_data_bus_oe_out,
  input wire logic byte_transfer_request_out,
  input wire logic floppy_irq_out,
  input wire logic motor_on_out,
  input wire logic write_gate_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ages saturate so the counters never wrap
  int rd_age;
  int cmd_age;
  wire logic rd_sel = !select_n_in && bus_read_write_line_in;
  wire logic cmd_sel = !select_n_in && !bus_read_write_line_in && register_address_bits_in == 2'h0;
  always_ff @(posedge clk_sys_in) begin
    rd_age <= (rst_in || rd_sel) ? 0 : (rd_age < 99 ? rd_age + 1 : rd_age);
    cmd_age <= (rst_in || cmd_sel) ? 0 : (cmd_age < 99 ? cmd_age + 1 : cmd_age);
  end
  sequence data_held;
    (!select_n_in && register_address_bits_in == 2'h3) [*6];
  endsequence
  sequence inhibit_held;
    (!write_inhibit_n_in) [*8];
  endsequence
  chk_read_enable: assert property (io_data_bus_oe_out |-> rd_age <= 6)
    else $error("bus driven without a read select");
  chk_enable_delay: assert property ($rose(io_data_bus_oe_out) |-> !$past(select_n_in, 2))
    else $error("bus driven too soon after select");
  chk_data_clears: assert property (data_held |-> ##[0:3] !byte_transfer_request_out)
    else $error("request stands after data access");
  chk_inhibit_gate: assert property (inhibit_held |-> !write_gate_out)
    else $error("write gate while inhibited");
  chk_reset_quiet: assert property ($fell(rst_in) |->
    !floppy_irq_out && !byte_transfer_request_out && !write_gate_out && !motor_on_out)
    else $error("outputs not cleared by reset");
  chk_busy_cause: assert property ($rose(floppy_irq_out) |-> cmd_age <= 9)
    else $error("busy without a command");
  chk_request_busy: assert property (byte_transfer_request_out |-> floppy_irq_out)
    else $error("request outside a command");
  chk_gate_cause: assert property ($rose(write_gate_out) |-> floppy_irq_out && write_inhibit_n_in)
    else $error("write gate outside a write");
endmodule // fdcif_props
`default_nettype wire

// ==== verification/fdcif_cpu.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdcif_cpu (
  input wire logic clk_sys_in,
  input wire logic [7:0] bus_q_in,
  output logic select_n_out,
  output logic rw_out,
  output logic [1:0] addr_out,
  output logic [7:0] data_out
);
  initial begin
    select_n_out = 1'b1;
    rw_out = 1'b1;
    addr_out = 2'h0;
    data_out = 8'h00;
  end
  // one access per select, held 8 edges
  task automatic acc(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_in);
    select_n_out <= 1'b0;
    rw_out <= ~wr;
    addr_out <= a;
    data_out <= wr ? d : ~data_out;
    repeat (8) @(posedge clk_sys_in);
    q = bus_q_in;
    select_n_out <= 1'b1;
    // released lines never keep the old byte
    data_out <= ~data_out;
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule // fdcif_cpu
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SL = 8;
  localparam int TL = 64;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic io_rst_n = 1'b1, wp_n = 1'b1, tz_n = 1'b1, idx_n = 1'b1, rd = 1'b0, rdv = 1'b0;
  logic found = 1'b0, nf = 1'b0, crc = 1'b0, del = 1'b0, rdy = 1'b0, inc = 1'b1;
  logic sel_n, rw, oe, req, irq, mot, wg, wd, wbv;
  logic [1:0] ad;
  logic [7:0] din, dout, q, wb, exp_b, nxt = 8'h30;
  logic irq_d = 1'b0;
  int failures = 0, comparisons = 0, cyc = 0, pops = 0, rises = 0, n0 = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  fdcif_cpu u_cpu (.clk_sys_in(clk_sys_in), .bus_q_in(dout), .select_n_out(sel_n), .rw_out(rw),
    .addr_out(ad), .data_out(din));
  fdcif_top #(.BYTE_CYC(64), .SECTOR_LEN(SL), .TRACK_LEN(TL), .TYPE1_CYC(200)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .io_reset_n_in(io_rst_n), .select_n_in(sel_n),
    .bus_read_write_line_in(rw), .register_address_bits_in(ad), .io_data_bus_in(din),
    .io_data_bus_out(dout), .io_data_bus_oe_out(oe), .byte_transfer_request_out(req),
    .floppy_irq_out(irq), .write_inhibit_n_in(wp_n), .track_zero_sense_n_in(tz_n), .index_n_in(idx_n),
    .read_data_in(rd), .read_bit_valid_in(rdv), .record_found_in(found), .record_not_found_in(nf),
    .crc_error_in(crc), .deleted_mark_in(del), .motor_on_out(mot), .write_gate_out(wg),
    .write_data_out(wd), .write_byte_out(wb), .write_byte_valid_out(wbv), .write_byte_ready_in(rdy));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // shortened track image: id field, then data field
  function automatic logic [7:0] fmt(input int i);
    if (i < 4) return 8'h4E;
    if (i < 16) return 8'h00;
    if (i < 19) return 8'hF5;
    if (i == 19) return 8'hFE;
    if (i == 20) return 8'h4C;
    if (i == 21) return 8'h01;
    if (i == 22) return 8'h1A;
    if (i == 23) return 8'h01;
    if (i == 24) return 8'hF7;
    if (i < 47) return 8'h4E;
    if (i < 59) return 8'h00;
    if (i < 62) return 8'hF5;
    if (i == 62) return 8'hFB;
    return 8'h3C;
  endfunction
  task automatic rdm(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
    u_cpu.acc(1'b0, a, 8'h00, q);
    chk({1'b0, q & m}, {1'b0, exp});
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    u_cpu.acc(1'b1, a, d, q);
  endtask
  task automatic wait_for(input bit use_irq, input logic v);
    int n;
    n = 0;
    while (((use_irq ? irq : req) !== v) && n < 5000) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk({8'h00, use_irq ? irq : req}, {8'h00, v});
  endtask
  task automatic strobe(input logic [2:0] m);
    @(posedge clk_sys_in);
    {found, nf, crc} <= m;
    @(posedge clk_sys_in);
    {found, nf, crc} <= 3'h0;
  endtask
  task automatic feed(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_sys_in);
      rd <= b[i];
      rdv <= 1'b1;
      @(posedge clk_sys_in);
      rdv <= 1'b0;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // sink stalls half the time; the skid buffer must lose nothing
  always @(posedge clk_sys_in) begin
    cyc++;
    rdy <= cyc[2];
    irq_d <= irq;
    if (irq === 1'b1 && irq_d === 1'b0) rises++;
    if (wbv && rdy) begin
      exp_b = inc ? nxt : fmt(pops);
      chk({wg, wb}, {1'b1, exp_b});
      chk({8'h00, wd}, {8'h00, exp_b[7]});
      pops++;
      if (inc) nxt <= nxt + 8'h01;
    end
    if (cyc == 60000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rdm(2'h0, 8'hFF, 8'h00);
    rdm(2'h1, 8'hFF, 8'h00);
    rdm(2'h2, 8'hFF, 8'h01);
    wr(2'h1, 8'h4C);
    wr(2'h2, 8'h1A);
    rdm(2'h1, 8'hFF, 8'h4C);
    rdm(2'h2, 8'hFF, 8'h1A);
    $display("test registers done");
    tz_n <= 1'b0;
    wr(2'h0, 8'h00);
    wait_for(1, 1'b1);
    rdm(2'h0, 8'hDF, {mot, 4'h0, 3'h5});
    wait_for(1, 1'b0);
    tz_n <= 1'b1;
    wr(2'h0, 8'hD0);
    rdm(2'h0, 8'h7F, 8'h00);
    $display("test type one done");
    wr(2'h0, 8'h80);
    strobe(3'h3);
    wait_for(1, 1'b0);
    rdm(2'h0, 8'h19, 8'h18);
    wr(2'h0, 8'h80);
    rdm(2'h0, 8'h19, 8'h01);
    wr(2'h0, 8'hD0);
    wait_for(1, 1'b0);
    $display("test status done");
    wr(2'h2, 8'h03);
    wr(2'h0, 8'h80);
    strobe(3'h4);
    for (int i = 0; i < SL; i++) begin
      feed(8'hA5);
      wait_for(0, 1'b1);
      rdm(2'h0, 8'h03, 8'h03);
      rdm(2'h3, 8'hFF, 8'hA5);
      wait_for(0, 1'b0);
    end
    wait_for(1, 1'b0);
    rdm(2'h0, 8'h25, 8'h00);
    $display("test read sector done");
    pops = 0;
    wr(2'h0, 8'hA0);
    strobe(3'h4);
    for (int i = 0; i < SL; i++) begin
      wait_for(0, 1'b1);
      wr(2'h3, 8'h30 + 8'(i));
      wait_for(0, 1'b0);
    end
    wait_for(1, 1'b0);
    repeat (16) @(posedge clk_sys_in);
    chk(9'(pops), 9'(SL));
    $display("test write sector done");
    wp_n <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      n0 = rises;
      wr(2'h0, k ? 8'hF0 : 8'hA0);
      wait_for(1, 1'b0);
      chk(9'(rises - n0), 9'h001);
      rdm(2'h0, 8'h41, 8'h40);
    end
    wp_n <= 1'b1;
    $display("test protect done");
    pops = 0;
    nxt <= 8'h4E;
    inc <= 1'b0;
    wr(2'h0, 8'hF0);
    idx_n <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    idx_n <= 1'b1;
    for (int i = 0; i < TL; i++) begin
      wait_for(0, 1'b1);
      wr(2'h3, fmt(i));
    end
    wait_for(1, 1'b0);
    repeat (16) @(posedge clk_sys_in);
    chk(9'(pops), 9'(TL));
    $display("test write track done");
    io_rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    io_rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    rdm(2'h0, 8'hFF, 8'h00);
    rdm(2'h1, 8'hFF, 8'h00);
    rdm(2'h2, 8'hFF, 8'h01);
    $display("test pin reset done");
    end_of_test();
  end
endmodule // tb_top
bind fdcif_top fdcif_props u_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .select_n_in(select_n_in),
  .bus_read_write_line_in(bus_read_write_line_in), .register_address_bits_in(register_address_bits_in),
  .write_inhibit_n_in(write_inhibit_n_in), .io_data_bus_oe_out(io_data_bus_oe_out),
  .byte_transfer_request_out(byte_transfer_request_out), .floppy_irq_out(floppy_irq_out),
  .motor_on_out(motor_on_out), .write_gate_out(write_gate_out));
`default_nettype wire
